// >>> gtaa_pkg.sv
/*
  Package for the gated 16-bit timer with atomic wide access: register
  offsets, field positions, reset values and bus state enumeration.
  Assumes a 32-bit Avalon-MM slave with byte addresses, one word per register.
*/
package gtaa_pkg;

  // ----------------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [3:0] GTAA_ADDR_COUNT_LOW  = 4'h0;
  localparam logic [3:0] GTAA_ADDR_COUNT_HIGH = 4'h4;
  localparam logic [3:0] GTAA_ADDR_TIMER_CTRL = 4'h8;
  localparam logic [3:0] GTAA_ADDR_GATE_CTRL  = 4'hC;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int GTAA_CTRL_ON_BIT    = 0;  // Timer run bit
  localparam int GTAA_CTRL_WIDE_BIT  = 1;  // wide_access_enable
  localparam int GTAA_CTRL_PRE_LSB   = 4;  // Prescale select, two bits
  localparam int GTAA_GATE_EN_BIT    = 7;  // gate_enable_bit
  localparam int GTAA_GATE_POL_BIT   = 6;  // gate_polarity_bit
  localparam int GTAA_GATE_LVL_BIT   = 3;  // Read-only gate level

  // ----------------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------------
  localparam int         GTAA_BYTE_W      = 8;
  localparam int         GTAA_PRE_W       = 3;
  localparam logic [7:0] GTAA_CTRL_RST    = 8'h00;
  localparam logic [7:0] GTAA_GATE_RST    = 8'h00;
  localparam logic [7:0] GTAA_BYTE_RST    = 8'h00;
  localparam logic [2:0] GTAA_PRE_RST     = 3'h0;
  localparam logic [31:0] GTAA_UNMAPPED   = 32'h0000_0000;

  // Bus answer sequencing
  typedef enum logic [0:0] {
    GTAA_BUS_IDLE,
    GTAA_BUS_ACK
  } gtaa_bus_state_t;

endpackage : gtaa_pkg

// >>> gtaa_edge_detect.sv
/*
  Rising edge detector for the timer clock source input.
  Assumes the source is already synchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none

module gtaa_edge_detect (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic level_in,
  output logic      rise_pulse
);
  import gtaa_pkg::*;

  logic level_r;

  // ----------------------------------------------------------------------
  // Previous level register
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      level_r <= 1'b0;
    end else begin
      level_r <= level_in;
    end
  end

  // One-cycle pulse on a low-to-high change
  assign rise_pulse = level_in & ~level_r;

endmodule // gtaa_edge_detect

`default_nettype wire

// >>> gtaa_gate_qual.sv
/*
  Gate qualifier: decides whether the counter may advance this cycle.
  Assumes gate_signal is synchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none

module gtaa_gate_qual (
  input  wire logic gate_enable_bit,
  input  wire logic gate_polarity_bit,
  input  wire logic gate_signal,
  output logic      count_allow
);
  import gtaa_pkg::*;

  // Free running unless gating is on; then the gate must match polarity
  assign count_allow = ~gate_enable_bit
                     | (gate_signal == gate_polarity_bit);

endmodule // gtaa_gate_qual

`default_nettype wire

// >>> gtaa_timer.sv
/*
  Gated 16-bit timer with atomic wide access, reached over Avalon-MM.
  Holds the count pair, the high byte shadow, the prescaler, the control
  and gate registers and the bus slave.
  Assumes timer_clock_source and gate_signal are synchronous to clk and
  that the bus master follows Avalon-MM waitrequest signalling.
*/
`timescale 1ns/1ps
`default_nettype none

module gtaa_timer (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        timer_clock_source,
  input  wire logic        gate_signal,
  output logic [15:0]      count_value,
  output logic             count_tick
);
  import gtaa_pkg::*;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic [7:0]       count_low_byte_r;
  logic [7:0]       count_high_byte_r;
  logic [7:0]       shadow_high_r;
  logic [7:0]       timer_control_reg_r;
  logic [7:0]       gate_control_reg_r;
  logic [2:0]       prescale_r;
  logic [2:0]       prescale_nxt;
  gtaa_bus_state_t  bus_state_r;
  logic [31:0]      readdata_nxt;

  logic             src_rise;
  logic             count_allow;
  logic             prescale_done;
  logic             advance;
  logic             wide_mode;
  logic             bus_go;
  logic             wr_low;
  logic             wr_high;
  logic             rd_low;
  logic [1:0]       pre_sel;
  logic [2:0]       pre_limit;
  logic [15:0]      count_inc;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  gtaa_edge_detect u_edge (
    .clk        (clk),
    .rst        (rst),
    .level_in   (timer_clock_source),
    .rise_pulse (src_rise)
  );

  gtaa_gate_qual u_gate (
    .gate_enable_bit   (gate_control_reg_r[GTAA_GATE_EN_BIT]),
    .gate_polarity_bit (gate_control_reg_r[GTAA_GATE_POL_BIT]),
    .gate_signal       (gate_signal),
    .count_allow       (count_allow)
  );

  // ----------------------------------------------------------------------
  // Bus access decode
  // ----------------------------------------------------------------------
  // A request is served once, in the cycle before waitrequest goes low
  assign bus_go    = (avs_read | avs_write) & (bus_state_r == GTAA_BUS_IDLE);
  assign wide_mode = timer_control_reg_r[GTAA_CTRL_WIDE_BIT];
  assign wr_low    = bus_go & avs_write & avs_byteenable[0]
                   & (avs_address == GTAA_ADDR_COUNT_LOW);
  assign wr_high   = bus_go & avs_write & avs_byteenable[0]
                   & (avs_address == GTAA_ADDR_COUNT_HIGH);
  assign rd_low    = bus_go & avs_read & (avs_address == GTAA_ADDR_COUNT_LOW);

  // ----------------------------------------------------------------------
  // Prescaler: divide source edges by 1, 2, 4 or 8
  // ----------------------------------------------------------------------
  assign pre_sel   = timer_control_reg_r[GTAA_CTRL_PRE_LSB +: 2];
  assign pre_limit = 3'(({2'b00, 1'b1} << pre_sel) - 3'h1);
  assign prescale_done = (prescale_r == pre_limit);

  // Prescaler only runs while the timer is on and the gate allows it
  always_comb begin
    prescale_nxt = prescale_r;
    if (wr_low) begin
      prescale_nxt = GTAA_PRE_RST;
    end else if (timer_control_reg_r[GTAA_CTRL_ON_BIT] && count_allow && src_rise) begin
      prescale_nxt = prescale_done ? GTAA_PRE_RST : 3'(prescale_r + 3'h1);
    end
  end

  // A high byte write deliberately does not touch the prescaler
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prescale_r <= GTAA_PRE_RST;
    end else begin
      prescale_r <= prescale_nxt;
    end
  end

  assign advance   = timer_control_reg_r[GTAA_CTRL_ON_BIT] & count_allow
                   & src_rise & prescale_done & ~wr_low;
  assign count_inc = 16'({count_high_byte_r, count_low_byte_r} + 16'h0001);

  // ----------------------------------------------------------------------
  // Count pair
  // ----------------------------------------------------------------------
  // A low byte write wins over an increment in the same cycle; that loses one
  // tick but keeps the written value exact, which is what software expects.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_low_byte_r <= GTAA_BYTE_RST;
    end else if (wr_low) begin
      count_low_byte_r <= avs_writedata[7:0];
    end else if (advance) begin
      count_low_byte_r <= count_inc[7:0];
    end
  end

  // Live high byte: wide mode loads it only from the shadow on a low write
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_high_byte_r <= GTAA_BYTE_RST;
    end else if (wr_low && wide_mode) begin
      count_high_byte_r <= shadow_high_r;
    end else if (wr_high && !wide_mode) begin
      count_high_byte_r <= avs_writedata[7:0];
    end else if (advance && !(wr_high && wide_mode)) begin
      count_high_byte_r <= count_inc[15:8];
    end else if (advance) begin
      count_high_byte_r <= count_inc[15:8];
    end
  end

  // Shadow: written by software in wide mode, loaded on low byte reads
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      shadow_high_r <= GTAA_BYTE_RST;
    end else if (wr_high && wide_mode) begin
      shadow_high_r <= avs_writedata[7:0];
    end else if (rd_low && wide_mode) begin
      shadow_high_r <= count_high_byte_r;
    end
  end

  // ----------------------------------------------------------------------
  // Control and gate registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      timer_control_reg_r <= GTAA_CTRL_RST;
    end else if (bus_go && avs_write && avs_byteenable[0]
                 && avs_address == GTAA_ADDR_TIMER_CTRL) begin
      timer_control_reg_r <= avs_writedata[7:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gate_control_reg_r <= GTAA_GATE_RST;
    end else if (bus_go && avs_write && avs_byteenable[0]
                 && avs_address == GTAA_ADDR_GATE_CTRL) begin
      gate_control_reg_r <= avs_writedata[7:0];
    end
  end

  // ----------------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------------
  // The low byte returns the live value; the shadow copy happens alongside
  always_comb begin
    readdata_nxt = GTAA_UNMAPPED;
    case (avs_address)
      GTAA_ADDR_COUNT_LOW:  readdata_nxt[7:0] = count_low_byte_r;
      GTAA_ADDR_COUNT_HIGH: readdata_nxt[7:0] = wide_mode ? shadow_high_r
                                                          : count_high_byte_r;
      GTAA_ADDR_TIMER_CTRL: readdata_nxt[7:0] = timer_control_reg_r;
      GTAA_ADDR_GATE_CTRL: begin
        readdata_nxt[7:0] = gate_control_reg_r;
        readdata_nxt[GTAA_GATE_LVL_BIT] = gate_signal;          // Live gate level
      end
      default:              readdata_nxt = GTAA_UNMAPPED;
    endcase
  end

  // ----------------------------------------------------------------------
  // Avalon handshake: waitrequest high at rest, low for one answer cycle
  // ----------------------------------------------------------------------
  // Holding waitrequest high at rest lets registered read data settle before
  // the master samples it, at the cost of one extra cycle per access.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bus_state_r <= GTAA_BUS_IDLE;
    end else begin
      case (bus_state_r)
        GTAA_BUS_IDLE: if (avs_read || avs_write) bus_state_r <= GTAA_BUS_ACK;
        GTAA_BUS_ACK:  bus_state_r <= GTAA_BUS_IDLE;
        default:       bus_state_r <= GTAA_BUS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= GTAA_UNMAPPED;
    end else begin
      avs_waitrequest <= ~bus_go;
      if (bus_go && avs_read) begin
        avs_readdata <= readdata_nxt;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Observation outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_value <= {GTAA_BYTE_RST, GTAA_BYTE_RST};
      count_tick  <= 1'b0;
    end else begin
      count_value <= {count_high_byte_r, count_low_byte_r};
      count_tick  <= advance;
    end
  end

endmodule // gtaa_timer

`default_nettype wire

// >>> gtaa_timer_monitor.sv
/*
  Checker for gtaa_timer: bus answer timing and count behaviour at the ports.
  Assumes it is bound to the timer top and that writes always set lane 0.
*/
`timescale 1ns/1ps
`default_nettype none

module gtaa_timer_monitor
  import gtaa_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [3:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        timer_clock_source,
  input wire logic        gate_signal,
  input wire logic [15:0] count_value,
  input wire logic        count_tick
);
  logic [7:0] ctl_r;
  logic [7:0] gat_r;
  logic       src_q;
  logic [2:0] since_r;

  // Copies of the control bytes, taken when a write completes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctl_r <= 8'h00;
      gat_r <= 8'h00;
    end else if (avs_write && !avs_waitrequest && avs_byteenable[0]) begin
      if (avs_address == GTAA_ADDR_TIMER_CTRL) ctl_r <= avs_writedata[7:0];
      if (avs_address == GTAA_ADDR_GATE_CTRL) gat_r <= avs_writedata[7:0];
    end
  end

  // Cycles since the last source rise, saturating so it never wraps
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      src_q   <= 1'b0;
      since_r <= 3'h7;
    end else begin
      src_q   <= timer_clock_source;
      since_r <= (timer_clock_source && !src_q) ? 3'h0 : since_r + {2'h0, since_r != 3'h7};
    end
  end

  // ----------------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_wait_one: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  // A new request is one whose strobe was low at the previous edge
  chk_req_answer: assert property ((avs_read && !$past(avs_read)) || (avs_write && !$past(avs_write))
    |=> !avs_waitrequest) else $error("request not answered after one wait cycle");
  // The tick pulse leads the count port by one cycle, so the step shows next cycle
  chk_tick_step: assert property (count_tick |=> count_value == $past(count_value) + 16'h1)
    else $error("tick without a step of one");
  chk_hold_count: assert property ($changed(count_value) |-> $past(count_tick)
    || ($past(avs_write) && !$past(avs_waitrequest))) else $error("count moved without cause");
  chk_gate_hold: assert property ((gat_r[7] && gate_signal != gat_r[6])[*4]
    |-> !count_tick) else $error("count advanced with gate inactive");
  chk_wide_high: assert property (ctl_r[1] && avs_write && !avs_waitrequest
    && avs_address == GTAA_ADDR_COUNT_HIGH |=> count_value == $past(count_value)
    + {15'h0, $past(count_tick)}) else $error("wide high write reached live count");
  chk_tick_cause: assert property (count_tick |-> since_r <= 3'h4)
    else $error("tick without a recent source rise");
  chk_run_off: assert property ((!ctl_r[0])[*4] |-> !count_tick)
    else $error("count advanced while stopped");
endmodule // gtaa_timer_monitor

bind gtaa_timer gtaa_timer_monitor u_mon (
  .clk               (clk),
  .rst               (rst),
  .avs_address       (avs_address),
  .avs_read          (avs_read),
  .avs_write         (avs_write),
  .avs_writedata     (avs_writedata),
  .avs_byteenable    (avs_byteenable),
  .avs_readdata      (avs_readdata),
  .avs_waitrequest   (avs_waitrequest),
  .timer_clock_source(timer_clock_source),
  .gate_signal       (gate_signal),
  .count_value       (count_value),
  .count_tick        (count_tick)
);

`default_nettype wire

// >>> gtaa_timer_tb.sv
/*
  Testbench for gtaa_timer: Avalon-MM register traffic, source edges, gate.
  Assumes the checker file is compiled with it.
*/
`timescale 1ns/1ps
`default_nettype none

module gtaa_timer_tb;
  import gtaa_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0]  avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        src = 1'b0;
  logic        gate = 1'b0;
  logic [15:0] count_value;
  logic        count_tick;
  logic [31:0] rd;
  int          n_fail = 0;
  int          checked = 0;
  int          cyc = 0;

  always #4 clk = ~clk;

  gtaa_timer DUT (
    .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .timer_clock_source(src), .gate_signal(gate), .count_value(count_value),
    .count_tick(count_tick)
  );

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic give_verdict;
    $display("checks %0d failures %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Request held until waitrequest is sampled low; no fixed latency assumed
  task automatic xfer(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= w;
    avs_read <= !w;
    // Ends when waitrequest is sampled low; only the bench timeout ends a hang
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic rdc(input string nm, input logic [3:0] a, input logic [7:0] e);
    xfer(1'b0, a, 8'h00);
    chk(nm, {24'h0, e}, rd);
  endtask

  // Count port lags the count, so let it settle first
  task automatic cnt(input string nm, input logic [15:0] e);
    repeat (2) @(posedge clk);
    chk(nm, {16'h0, e}, {16'h0, count_value});
  endtask

  task automatic edges(input int k);
    repeat (k) begin
      @(posedge clk);
      src <= 1'b1;
      repeat (2) @(posedge clk);
      src <= 1'b0;
      @(posedge clk);
    end
    repeat (4) @(posedge clk);
  endtask

  // Cuts a hang short
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      give_verdict();
    end
  end

  // ----------------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rdc("low", GTAA_ADDR_COUNT_LOW, 8'h00);
    rdc("high", GTAA_ADDR_COUNT_HIGH, 8'h00);
    rdc("ctrl", GTAA_ADDR_TIMER_CTRL, 8'h00);
    rdc("gate", GTAA_ADDR_GATE_CTRL, 8'h00);
    rdc("unmapped", 4'h2, 8'h00);
    $display("test reset done");
    xfer(1'b1, GTAA_ADDR_TIMER_CTRL, 8'h01);
    xfer(1'b1, GTAA_ADDR_COUNT_HIGH, 8'hFF);
    xfer(1'b1, GTAA_ADDR_COUNT_LOW, 8'hFE);
    edges(3);
    cnt("rollover", 16'h0001);
    rdc("narrow low", GTAA_ADDR_COUNT_LOW, 8'h01);
    rdc("narrow high", GTAA_ADDR_COUNT_HIGH, 8'h00);
    $display("test narrow done");
    xfer(1'b1, GTAA_ADDR_TIMER_CTRL, 8'h03);
    xfer(1'b1, GTAA_ADDR_COUNT_HIGH, 8'h12);
    cnt("wide high held", 16'h0001);
    rdc("shadow", GTAA_ADDR_COUNT_HIGH, 8'h12);
    xfer(1'b1, GTAA_ADDR_COUNT_LOW, 8'hFF);
    cnt("wide load", 16'h12FF);
    rdc("wide low", GTAA_ADDR_COUNT_LOW, 8'hFF);
    edges(1);
    cnt("wide carry", 16'h1300);
    rdc("stale shadow", GTAA_ADDR_COUNT_HIGH, 8'h12);
    rdc("wide low", GTAA_ADDR_COUNT_LOW, 8'h00);
    rdc("fresh shadow", GTAA_ADDR_COUNT_HIGH, 8'h13);
    xfer(1'b1, GTAA_ADDR_TIMER_CTRL, 8'h01);
    xfer(1'b1, GTAA_ADDR_COUNT_HIGH, 8'h40);
    cnt("direct high", 16'h4000);
    $display("test wide done");
    for (int p = 0; p < 4; p++) begin
      xfer(1'b1, GTAA_ADDR_TIMER_CTRL, 8'h01 | 8'(p << 4));
      xfer(1'b1, GTAA_ADDR_COUNT_LOW, 8'h00);
      edges((1 << p) - 1);
      cnt("prescale hold", 16'h4000);
      edges(1);
      cnt("prescale step", 16'h4001);
    end
    xfer(1'b1, GTAA_ADDR_TIMER_CTRL, 8'h11);
    xfer(1'b1, GTAA_ADDR_COUNT_LOW, 8'h00);
    edges(1);
    xfer(1'b1, GTAA_ADDR_COUNT_HIGH, 8'h05);
    edges(1);
    cnt("high keeps prescale", 16'h0501);
    edges(1);
    xfer(1'b1, GTAA_ADDR_COUNT_LOW, 8'h10);
    edges(1);
    cnt("low clears prescale", 16'h0510);
    $display("test prescale done");
    xfer(1'b1, GTAA_ADDR_TIMER_CTRL, 8'h01);
    // Every polarity and level, then gating off with the gate low
    for (int i = 0; i < 5; i++) begin
      @(posedge clk);
      gate <= i[0];
      xfer(1'b1, GTAA_ADDR_GATE_CTRL, i < 4 ? {1'b1, i[1], 6'h00} : 8'h40);
      xfer(1'b1, GTAA_ADDR_COUNT_LOW, 8'h00);
      edges(2);
      cnt("gate", {8'h05, (i == 4 || i[0] == i[1]) ? 8'h02 : 8'h00});
      // Gate control reads back its fields with the live gate level in bit 3
      rdc("gate read", GTAA_ADDR_GATE_CTRL,
          (i < 4 ? {1'b1, i[1], 6'h00} : 8'h40) | {4'h0, i[0], 3'h0});
    end
    // With the run bit clear, source edges must not move the count
    xfer(1'b1, GTAA_ADDR_TIMER_CTRL, 8'h00);
    edges(2);
    cnt("run off", 16'h0502);
    $display("test gate done");
    give_verdict();
  end
endmodule // gtaa_timer_tb

`default_nettype wire
